// [at_rtc_cmos_ram.sv]
// Purpose: battery-backed clock, calendar, alarm and 128 byte cmos ram
// Assumes: i/o strobes are one-cycle pulses synchronous to core_clk
// Notes: rst is the backup-well reset; ram and counters keep contents
`timescale 1ns/10ps
module at_rtc_cmos_ram #(
  parameter int unsigned TICKS_PER_SEC = 32768
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic io_port_sel,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [rtc_pkg::DATA_W-1:0] io_wdata,
  input wire logic ref_tick,
  input wire logic power_good,
  output logic [rtc_pkg::DATA_W-1:0] io_rdata,
  output logic irq,
  output logic sqw_out
);
  import rtc_pkg::*;

  localparam int unsigned PS_W = $clog2(TICKS_PER_SEC);
  localparam logic [PS_W-1:0] PS_LAST = PS_W'(TICKS_PER_SEC - 1);
  localparam logic [PS_W-1:0] PS_UIP =
    PS_W'(TICKS_PER_SEC - UIP_LEAD_TICKS);

  logic [ADDR_W-1:0] index_q;
  logic [DATA_W-1:0] mem_q [RAM_DEPTH];
  logic [6:0] rate_q;
  logic [7:0] ctrl_q;
  logic pf_q;
  logic af_q;
  logic uf_q;
  logic fall_done_q;
  logic [PS_W-1:0] prescale_q;

  logic wr_index;
  logic wr_data;
  logic rd_data;
  logic rd_flags;
  logic run;
  logic sec_tick;
  logic uip;
  logic irqf;
  logic bin;
  logic h24;
  logic per_pulse;
  logic sqw_level;

  assign wr_index = io_wr & (io_port_sel == PORT_INDEX);
  assign wr_data = io_wr & (io_port_sel == PORT_DATA);
  assign rd_data = io_rd & (io_port_sel == PORT_DATA);
  assign rd_flags = rd_data & (index_q == LOC_FLAGS);
  assign bin = ctrl_q[B_BIN];
  assign h24 = ctrl_q[B_24H];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      index_q <= '0;
    end else if (wr_index) begin
      index_q <= io_wdata[ADDR_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_q <= RATE_RST;
    end else if (wr_data && index_q == LOC_RATE) begin
      rate_q <= io_wdata[6:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_data && index_q == LOC_CTRL) begin
      ctrl_q <= io_wdata;
    end
  end

  // halt or a non-normal divider freezes the timebase
  assign run = ~ctrl_q[B_HALT] & (rate_q[6:4] == DV_NORMAL);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescale_q <= '0;
    end else if (!run) begin
      prescale_q <= '0;
    end else if (ref_tick) begin
      prescale_q <= (prescale_q == PS_LAST) ? '0 : prescale_q + 1'b1;
    end
  end

  assign sec_tick = run & ref_tick & (prescale_q == PS_LAST);
  // busy window before and through the roll
  assign uip = run & (prescale_q >= PS_UIP);

  rtc_rate_div #(
    .DIV_W(15)
  ) u_rate (
    .core_clk(core_clk),
    .rst(rst),
    .enable(rate_q[6:4] == DV_NORMAL),
    .ref_tick(ref_tick),
    .rate_sel(rate_q[3:0]),
    .per_pulse(per_pulse),
    .sqw_level(sqw_level)
  );

  assign sqw_out = ctrl_q[B_SQWE] & sqw_level;

  // calendar in binary for comparisons
  logic [6:0] hour_b;
  logic [6:0] hour_bn;
  logic [6:0] wday_b;
  logic [6:0] mday_b;
  logic [6:0] mon_b;
  logic [6:0] year_b;
  logic [6:0] dim;
  logic pm;
  logic pm_n;
  logic day_carry;
  logic fall_hit;
  logic spring;
  logic fall;
  logic [7:0] hour_nxt;
  logic [7:0] hour_enc;
  logic [7:0] sec_nxt;
  logic [7:0] min_nxt;
  logic [7:0] wday_nxt;
  logic [7:0] mday_nxt;
  logic [7:0] mon_nxt;
  logic [7:0] year_nxt;
  logic sec_wrap;
  logic min_wrap;
  logic mday_wrap;
  logic mon_wrap;
  logic upd_min;
  logic upd_hour;
  logic upd_day;
  logic alarm_hit;

  // hour, day, month and year decoded per the format bit
  always_comb begin
    pm = ~h24 & mem_q[LOC_HOUR][7];
    hour_b = to_bin({1'b0, mem_q[LOC_HOUR][6:0]}, bin);
    wday_b = to_bin(mem_q[LOC_WDAY], bin);
    mday_b = to_bin(mem_q[LOC_MDAY], bin);
    mon_b = to_bin(mem_q[LOC_MONTH], bin);
    year_b = to_bin(mem_q[LOC_YEAR], bin);
    case (mon_b)
      7'd2: dim = (year_b[1:0] == 2'h0) ? 7'd29 : 7'd28;
      7'd4, 7'd6, 7'd9, 7'd11: dim = 7'd30;
      default: dim = 7'd31;
    endcase
  end

  // spring forward first april sunday, fall back last october
  assign spring = ctrl_q[B_DST] & (mon_b == 7'd4) & (wday_b == 7'd1) &
    (mday_b <= 7'd7);
  assign fall = ctrl_q[B_DST] & (mon_b == 7'd10) & (wday_b == 7'd1) &
    (mday_b >= 7'd25) & ~fall_done_q;

  always_comb begin
    hour_bn = 7'(hour_b + 7'd1);
    pm_n = pm;
    day_carry = 1'b0;
    fall_hit = 1'b0;
    if (h24) begin
      if (hour_b >= 7'd23) begin
        hour_bn = 7'd0;
        day_carry = 1'b1;
      end
    end else begin
      if (hour_b >= 7'd12) begin
        hour_bn = 7'd1;
      end else if (hour_b == 7'd11) begin
        pm_n = ~pm;
        day_carry = pm;
      end
    end
    if (spring && hour_b == 7'd1 && !pm) begin
      hour_bn = 7'd3;
    end
    if (fall && hour_b == 7'd1 && !pm) begin
      hour_bn = 7'd1;
      fall_hit = 1'b1;
    end
    // a function result cannot be part-selected, so stage it
    hour_enc = from_bin(hour_bn, bin);
    hour_nxt = {pm_n, hour_enc[6:0]};
  end

  rtc_field_inc u_sec (
    .cur(mem_q[LOC_SEC]), .bin_mode(bin), .lo(7'd0), .hi(7'd59),
    .nxt(sec_nxt), .wrap(sec_wrap)
  );
  rtc_field_inc u_min (
    .cur(mem_q[LOC_MIN]), .bin_mode(bin), .lo(7'd0), .hi(7'd59),
    .nxt(min_nxt), .wrap(min_wrap)
  );
  rtc_field_inc u_wday (
    .cur(mem_q[LOC_WDAY]), .bin_mode(bin), .lo(7'd1), .hi(7'd7),
    .nxt(wday_nxt), .wrap()
  );
  rtc_field_inc u_mday (
    .cur(mem_q[LOC_MDAY]), .bin_mode(bin), .lo(7'd1), .hi(dim),
    .nxt(mday_nxt), .wrap(mday_wrap)
  );
  rtc_field_inc u_mon (
    .cur(mem_q[LOC_MONTH]), .bin_mode(bin), .lo(7'd1), .hi(7'd12),
    .nxt(mon_nxt), .wrap(mon_wrap)
  );
  rtc_field_inc u_year (
    .cur(mem_q[LOC_YEAR]), .bin_mode(bin), .lo(7'd0), .hi(7'd99),
    .nxt(year_nxt), .wrap()
  );

  assign upd_min = sec_tick & sec_wrap;
  assign upd_hour = upd_min & min_wrap;
  assign upd_day = upd_hour & day_carry;

  // alarm compares post-update values; top bits 11 match any
  always_comb begin
    alarm_hit = sec_tick;
    if (mem_q[LOC_SEC_ALM][7:6] != ALM_ANY &&
        mem_q[LOC_SEC_ALM] != sec_nxt) begin
      alarm_hit = 1'b0;
    end
    if (mem_q[LOC_MIN_ALM][7:6] != ALM_ANY && mem_q[LOC_MIN_ALM] !=
        (upd_min ? min_nxt : mem_q[LOC_MIN])) begin
      alarm_hit = 1'b0;
    end
    if (mem_q[LOC_HOUR_ALM][7:6] != ALM_ANY && mem_q[LOC_HOUR_ALM] !=
        (upd_hour ? hour_nxt : mem_q[LOC_HOUR])) begin
      alarm_hit = 1'b0;
    end
  end

  // one fall-back per october; cleared once the month moves on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fall_done_q <= 1'b0;
    end else if (upd_hour && fall_hit) begin
      fall_done_q <= 1'b1;
    end else if (mon_b != 7'd10) begin
      fall_done_q <= 1'b0;
    end
  end

  // no reset on the array: contents ride through power loss
  // host writes to 0Ah-0Bh land in status logic and 0Ch-0Dh are dropped, none here
  always_ff @(posedge core_clk) begin
    if (sec_tick) begin
      mem_q[LOC_SEC] <= sec_nxt;
    end
    if (upd_min) begin
      mem_q[LOC_MIN] <= min_nxt;
    end
    if (upd_hour) begin
      mem_q[LOC_HOUR] <= hour_nxt;
    end
    if (upd_day) begin
      mem_q[LOC_WDAY] <= wday_nxt;
      mem_q[LOC_MDAY] <= mday_nxt;
    end
    if (upd_day && mday_wrap) begin
      mem_q[LOC_MONTH] <= mon_nxt;
    end
    if (upd_day && mday_wrap && mon_wrap) begin
      mem_q[LOC_YEAR] <= year_nxt;
    end
    // host data write; last assignment wins over the roll
    if (wr_data && (index_q < LOC_RATE || index_q > LOC_POWER)) begin
      mem_q[index_q] <= io_wdata;
    end
  end

  // read clears; a same-cycle event still sets the flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pf_q <= 1'b0;
      af_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      pf_q <= per_pulse | (pf_q & ~rd_flags);
      af_q <= alarm_hit | (af_q & ~rd_flags);
      uf_q <= sec_tick | (uf_q & ~rd_flags);
    end
  end

  assign irqf = (pf_q & ctrl_q[B_PIE]) | (af_q & ctrl_q[B_AIE]) |
    (uf_q & ctrl_q[B_UIE]);
  assign irq = irqf;

  // registered read data, one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io_rdata <= '0;
    end else if (io_rd && io_port_sel == PORT_INDEX) begin
      io_rdata <= {1'b0, index_q};
    end else if (rd_data) begin
      case (index_q)
        LOC_RATE: io_rdata <= {uip, rate_q};
        LOC_CTRL: io_rdata <= ctrl_q;
        LOC_FLAGS: io_rdata <= {irqf, pf_q, af_q, uf_q, 4'h0};
        // power-valid bit from the supply monitor
        LOC_POWER: io_rdata <= {power_good, 7'h00};
        default: io_rdata <= mem_q[index_q];
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_uip_on_roll: assert property (
    sec_tick |-> uip ##0 $past(prescale_q) >= PS_UIP - 1'b1)
    else $error("second rolled without busy flag");
  chk_halt_stops: assert property (
    ctrl_q[B_HALT] |-> !sec_tick ##1
      ($stable(mem_q[LOC_SEC]) || $past(wr_data)))
    else $error("counters moved while halted");
  chk_index_holds: assert property (
    !wr_index |=> $stable(index_q))
    else $error("index changed without a write");
  chk_flag_clear: assert property (
    rd_flags && !sec_tick && !per_pulse && !alarm_hit
    |=> !pf_q && !uf_q && !irq)
    else $error("flags survived a status read");
  chk_update_irq: assert property (
    sec_tick && ctrl_q[B_UIE] && !(wr_data && index_q == LOC_CTRL) |=> irq)
    else $error("enabled update event gave no interrupt");
  chk_flags_read: assert property (
    rd_flags |=> io_rdata[7] == $past(irqf) && io_rdata[3:0] == 4'h0)
    else $error("status flags read back wrong");
  chk_power_read: assert property (
    rd_data && index_q == LOC_POWER |=> io_rdata == {$past(power_good), 7'h00})
    else $error("power-valid read wrong");
  chk_sec_step: assert property (
    sec_tick && bin && mem_q[LOC_SEC] < 8'h3b && !wr_data
    |=> mem_q[LOC_SEC] == $past(mem_q[LOC_SEC]) + 8'h01)
    else $error("binary seconds did not step by one");
  chk_ram_read: assert property (
    rd_data && index_q > LOC_POWER |=> io_rdata == $past(mem_q[index_q]))
    else $error("ram read returned wrong byte");

  cov_second_roll: cover property (upd_min);
  cov_alarm_fire: cover property (alarm_hit ##1 af_q);
  cov_read_irq: cover property (rd_flags && irq ##1 !irq);

endmodule // at_rtc_cmos_ram

// [rtc_pkg.sv]
// Purpose: shared constants for the battery-backed clock and cmos ram
// Assumes: 8-bit legacy i/o data path, 128 byte ram
// Notes: bcd helpers are shared by the top and the field incrementer
package rtc_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned RAM_DEPTH = 128;

  // port select: index port or data port
  localparam logic PORT_INDEX = 1'b0;
  localparam logic PORT_DATA = 1'b1;

  // clock locations
  localparam logic [6:0] LOC_SEC = 7'h00;
  localparam logic [6:0] LOC_SEC_ALM = 7'h01;
  localparam logic [6:0] LOC_MIN = 7'h02;
  localparam logic [6:0] LOC_MIN_ALM = 7'h03;
  localparam logic [6:0] LOC_HOUR = 7'h04;
  localparam logic [6:0] LOC_HOUR_ALM = 7'h05;
  localparam logic [6:0] LOC_WDAY = 7'h06;
  localparam logic [6:0] LOC_MDAY = 7'h07;
  localparam logic [6:0] LOC_MONTH = 7'h08;
  localparam logic [6:0] LOC_YEAR = 7'h09;
  localparam logic [6:0] LOC_RATE = 7'h0a;
  localparam logic [6:0] LOC_CTRL = 7'h0b;
  localparam logic [6:0] LOC_FLAGS = 7'h0c;
  localparam logic [6:0] LOC_POWER = 7'h0d;
  localparam logic [6:0] LOC_DIAG = 7'h0e;
  localparam logic [6:0] LOC_CENTURY = 7'h32;

  // field positions
  localparam int unsigned A_UIP = 7;
  localparam int unsigned B_HALT = 7;
  localparam int unsigned B_PIE = 6;
  localparam int unsigned B_AIE = 5;
  localparam int unsigned B_UIE = 4;
  localparam int unsigned B_SQWE = 3;
  localparam int unsigned B_BIN = 2;
  localparam int unsigned B_24H = 1;
  localparam int unsigned B_DST = 0;
  localparam int unsigned D_VRT = 7;

  // values after reset, divider and alarm codes
  localparam logic [6:0] RATE_RST = 7'h20;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [2:0] DV_NORMAL = 3'h2;
  localparam logic [1:0] ALM_ANY = 2'h3;

  // update window, in reference ticks ahead of the second roll
  localparam int unsigned UIP_LEAD_TICKS = 8;

  function automatic logic [6:0] to_bin(input logic [7:0] v,
                                        input logic bin);
    return bin ? v[6:0] :
      7'({3'h0, v[7:4]} * 7'd10 + {3'h0, v[3:0]});
  endfunction

  function automatic logic [7:0] from_bin(input logic [6:0] b,
                                          input logic bin);
    return bin ? {1'b0, b} : {4'(b / 7'd10), 4'(b % 7'd10)};
  endfunction

endpackage

// [rtc_field_inc.sv]
// Purpose: one step of a wrapping time field, bcd or binary
// Assumes: current value lies inside lo..hi
// Notes: pure combinational, used once per calendar field except the hour
`timescale 1ns/10ps
module rtc_field_inc (
  input wire logic [rtc_pkg::DATA_W-1:0] cur,
  input wire logic bin_mode,
  input wire logic [6:0] lo,
  input wire logic [6:0] hi,
  output logic [rtc_pkg::DATA_W-1:0] nxt,
  output logic wrap
);
  import rtc_pkg::*;

  logic [6:0] cur_b;
  logic [6:0] nxt_b;

  // values at or above hi wrap to lo, so garbage heals in a step
  always_comb begin
    cur_b = to_bin(cur, bin_mode);
    wrap = (cur_b >= hi);
    nxt_b = wrap ? lo : 7'(cur_b + 7'd1);
    nxt = from_bin(nxt_b, bin_mode);
  end

endmodule // rtc_field_inc

// [rtc_rate_div.sv]
// Purpose: periodic interrupt and square wave divider
// Assumes: ref_tick is a one-cycle pulse of the timebase
// Notes: rate 0 stops both outputs; rate n taps counter bit n-1
`timescale 1ns/10ps
module rtc_rate_div #(
  parameter int unsigned DIV_W = 15
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic ref_tick,
  input wire logic [3:0] rate_sel,
  output logic per_pulse,
  output logic sqw_level
);
  import rtc_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic tap_q;
  logic tap;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!enable) begin
      cnt_q <= '0;
    end else if (ref_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tap = (rate_sel == 4'h0) ? 1'b0 : cnt_q[4'(rate_sel - 4'h1)];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap;
    end
  end

  assign per_pulse = tap & ~tap_q;
  assign sqw_level = tap_q;

endmodule // rtc_rate_div

// [rtc_io_host.sv]
// Purpose: host processor model on the index and data ports
// Assumes: strobes taken on rising core_clk, read answer holds
// Notes: drives at falling edge; idle write data is inverted
`timescale 1ns/10ps
module rtc_io_host (
  input wire logic core_clk,
  input wire logic [rtc_pkg::DATA_W-1:0] io_rdata,
  output logic io_port_sel,
  output logic io_wr,
  output logic io_rd,
  output logic [rtc_pkg::DATA_W-1:0] io_wdata
);
  import rtc_pkg::*;
  initial begin
    io_port_sel = PORT_INDEX;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // one write strobe; stale data never left on the bus
  task automatic put(input logic sel, input logic [7:0] d);
    @(negedge core_clk);
    io_port_sel = sel;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask
  // answer sampled two edges on, it stands until next read
  task automatic get(input logic sel, output logic [7:0] d);
    @(negedge core_clk);
    io_port_sel = sel;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    @(negedge core_clk);
    d = io_rdata;
  endtask
  task automatic wr_loc(input logic [6:0] loc, input logic [7:0] v);
    put(PORT_INDEX, {1'b0, loc});
    put(PORT_DATA, v);
  endtask
  task automatic rd_loc(input logic [6:0] loc, output logic [7:0] v);
    put(PORT_INDEX, {1'b0, loc});
    get(PORT_DATA, v);
  endtask
endmodule // rtc_io_host

// [at_rtc_cmos_ram_tb.sv]
// Purpose: self-checking bench for the clock and cmos ram block
// Assumes: short second of 16 reference ticks
// Notes: ram is not reset, so only written places are compared
`timescale 1ns/10ps
module at_rtc_cmos_ram_tb;
  import rtc_pkg::*;
  localparam int TPS = 16;
  localparam logic [7:0] SET_T [10] = '{8'h59, 8'hc0, 8'h59, 8'hc0,
    8'h23, 8'hc0, 8'h07, 8'h28, 8'h02, 8'h23};
  localparam logic [7:0] ROLL_T [10] = '{8'h00, 8'hc0, 8'h00, 8'hc0,
    8'h00, 8'hc0, 8'h01, 8'h01, 8'h03, 8'h23};
  logic core_clk, rst, io_port_sel, io_wr, io_rd, ref_tick, power_good;
  logic irq, sqw_out;
  logic [7:0] io_wdata, io_rdata, v;
  logic [7:0] shadow [128];
  logic [1:0] saw;
  int errors = 0;
  int check_count = 0;
  int seed = 32'h9327;
  int cycles = 0;

  at_rtc_cmos_ram #(.TICKS_PER_SEC(TPS)) at_rtc_cmos_ram_i (
    .core_clk(core_clk), .rst(rst), .io_port_sel(io_port_sel),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .ref_tick(ref_tick), .power_good(power_good),
    .io_rdata(io_rdata), .irq(irq), .sqw_out(sqw_out));
  rtc_io_host host_i (
    .core_clk(core_clk), .io_rdata(io_rdata), .io_port_sel(io_port_sel),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the whole run needs little more than a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error at %0t: run did not finish", $time);
      end_sim();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: %s got %b want %b", $time, m, g, e);
    end
  endtask

  task automatic rdc(input logic [6:0] loc, input logic [7:0] e,
                     input string m);
    logic [7:0] g;
    host_i.rd_loc(loc, g);
    chk8(g, e, m);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge core_clk);
      ref_tick = 1'b1;
      @(negedge core_clk);
      ref_tick = 1'b0;
    end
  endtask

  function automatic logic [7:0] enc(input int n, input logic bin);
    return bin ? 8'(n) : 8'((n / 10) * 16 + n % 10);
  endfunction

  function automatic logic [15:0] csum(input int lo, input int hi);
    logic [15:0] s;
    s = 16'h0000;
    for (int a = lo; a <= hi; a++) s += {8'h00, shadow[a]};
    return s;
  endfunction

  task automatic fw_block(input int lo, input int hi, input int dst);
    logic [15:0] s;
    for (int a = lo; a <= hi; a++) begin
      shadow[a] = 8'($random(seed));
      host_i.wr_loc(7'(a), shadow[a]);
    end
    s = csum(lo, hi);
    shadow[dst] = s[15:8];
    shadow[dst + 1] = s[7:0];
    host_i.wr_loc(7'(dst), s[15:8]);
    host_i.wr_loc(7'(dst + 1), s[7:0]);
  endtask

  initial begin
    rst = 1'b1;
    ref_tick = 1'b0;
    power_good = 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    rdc(LOC_RATE, 8'h20, "rate reset");
    rdc(LOC_CTRL, 8'h02, "ctrl reset");
    rdc(LOC_FLAGS, 8'h00, "flags reset");
    host_i.wr_loc(LOC_FLAGS, 8'hff);
    rdc(LOC_FLAGS, 8'h00, "flags read only");
    host_i.wr_loc(LOC_RATE, 8'ha0);
    rdc(LOC_RATE, 8'h20, "busy bit read only");
    host_i.wr_loc(LOC_POWER, 8'h00);
    rdc(LOC_POWER, 8'h80, "power kept");
    power_good = 1'b0;
    rdc(LOC_POWER, 8'h00, "power lost");
    power_good = 1'b1;
    // index bit 7 is dropped and the index persists
    host_i.put(PORT_INDEX, 8'ha0);
    host_i.get(PORT_INDEX, v);
    chk8(v, 8'h20, "index readback");
    host_i.put(PORT_DATA, 8'h5a);
    host_i.get(PORT_DATA, v);
    chk8(v, 8'h5a, "first data read");
    host_i.get(PORT_DATA, v);
    chk8(v, 8'h5a, "second data read");
    fw_block(16, 45, 46);
    fw_block(64, 91, 92);
    fw_block(111, 125, 126);
    shadow[14] = 8'h80;
    host_i.wr_loc(LOC_DIAG, 8'h80);
    shadow[50] = 8'h20;
    host_i.wr_loc(LOC_CENTURY, 8'h20);
    for (int a = 14; a < 128; a++) begin
      if (a == 14 || a == 50 || (a >= 16 && a <= 47) ||
          (a >= 64 && a <= 93) || a >= 111) begin
        rdc(7'(a), shadow[a], "ram retained");
      end
    end
    // halted while setting the time, then run to the roll
    // seconds defined first: the array comes up unknown
    host_i.wr_loc(LOC_SEC, SET_T[0]);
    host_i.wr_loc(LOC_CTRL, 8'hb2);
    for (int i = 0; i < 10; i++) host_i.wr_loc(7'(i), SET_T[i]);
    host_i.wr_loc(LOC_CTRL, 8'h32);
    tick(TPS - 9);
    rdc(LOC_RATE, 8'h20, "not yet busy");
    tick(1);
    rdc(LOC_RATE, 8'ha0, "update busy");
    tick(TPS - 9);
    chk1(irq, 1'b0, "irq before roll");
    tick(1);
    chk1(irq, 1'b1, "irq after roll");
    rdc(LOC_FLAGS, 8'hb0, "update and alarm flags");
    chk1(irq, 1'b0, "irq cleared by read");
    rdc(LOC_FLAGS, 8'h00, "flags cleared");
    for (int i = 0; i < 10; i++) begin
      rdc(7'(i), ROLL_T[i], "after roll");
    end
    // twelve-hour noon crossing in both data formats
    for (int b = 0; b < 2; b++) begin
      host_i.wr_loc(LOC_CTRL, {5'b10000, b[0], 2'b00});
      host_i.wr_loc(LOC_SEC, enc(59, b[0]));
      host_i.wr_loc(LOC_MIN, enc(59, b[0]));
      host_i.wr_loc(LOC_HOUR, enc(11, b[0]));
      host_i.wr_loc(LOC_CTRL, {5'b00000, b[0], 2'b00});
      tick(TPS);
      rdc(LOC_SEC, enc(0, b[0]), "second wrap");
      rdc(LOC_HOUR, 8'h80 | enc(12, b[0]), "noon");
      host_i.wr_loc(LOC_CTRL, {5'b10000, b[0], 2'b00});
      tick(TPS);
      rdc(LOC_SEC, enc(0, b[0]), "halted");
    end
    // binary run, so the seconds step from zero is also seen
    host_i.wr_loc(LOC_CTRL, 8'h4f);
    rdc(LOC_CTRL, 8'h4f, "ctrl readback");
    host_i.wr_loc(LOC_RATE, 8'h23);
    host_i.rd_loc(LOC_FLAGS, v);
    saw = 2'b00;
    repeat (16) begin
      tick(1);
      saw = saw | {sqw_out === 1'b1, sqw_out === 1'b0};
    end
    chk8({6'h00, saw}, 8'h03, "square wave toggles");
    chk1(irq, 1'b1, "periodic irq");
    host_i.rd_loc(LOC_FLAGS, v);
    chk8(v & 8'hc0, 8'hc0, "periodic flag");
    host_i.wr_loc(LOC_RATE, 8'h20);
    host_i.rd_loc(LOC_FLAGS, v);
    tick(TPS);
    host_i.rd_loc(LOC_FLAGS, v);
    chk8(v & 8'h40, 8'h00, "rate off");
    end_sim();
  end
endmodule // at_rtc_cmos_ram_tb
